/* File: pkg/trr_pkg.sv */
package trr_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CONV_TRIGGER_OPTIONS_OFS = 8'h00;
  localparam logic [7:0] TIMER_SOURCE_OPTIONS_OFS = 8'h04;
  localparam logic [7:0] SERIAL_SOURCE_OPTIONS_OFS = 8'h08;
  localparam logic [7:0] TIMER_TRIGGER_CONFIG_OFS = 8'h0c;
  localparam logic [7:0] ROUTE_ENABLE_OFS = 8'h10;
  localparam logic [7:0] SOURCE_STATUS_OFS = 8'h14;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTO_PRETRIG_BIT = 0;
  localparam int CTO_ALT_EN_BIT = 7;
  localparam int CTO_SRC_LSB = 8;
  localparam int TSO_T1_CAP_BIT = 0;
  localparam int TSO_T2_CAP_BIT = 1;
  localparam int SSO_RX0_BIT = 0;
  localparam int SSO_RX1_BIT = 1;
  localparam int SSO_TX0_LSB = 2;
  localparam int SSO_TX1_LSB = 4;
  localparam int TTC_STRIDE = 8;
  localparam int TTC_GTB_BIT = 4;
  localparam int REN_CMP_TRIG_BIT = 0;
  localparam int REN_TOUCH_BIT = 1;
  localparam int REN_DAC_BIT = 2;
  localparam int REN_DMA0_BIT = 3;
  localparam int REN_DMA1_BIT = 4;

  // ****************************************
  // Event sources and selector codes
  // ****************************************
  localparam int NUM_TIMERS = 3;
  localparam int NUM_EV = 14;
  localparam int EV_EXT = 0;
  localparam int EV_CMP = 1;
  localparam int EV_PIT0 = 2;
  localparam int EV_PIT1 = 3;
  localparam int EV_TOF0 = 4;
  localparam int EV_TOF1 = 5;
  localparam int EV_TOF2 = 6;
  localparam int EV_RTC_ALARM = 7;
  localparam int EV_RTC_SEC = 8;
  localparam int EV_LPT = 9;
  localparam int EV_T1_CHANNEL0_FLAG = 10;
  localparam int EV_T1_CHANNEL1_FLAG = 11;
  localparam int EV_T1_CH0_OUT = 12;
  localparam int EV_T2_CH0_OUT = 13;
  localparam logic [3:0] NUM_SEL_CODES = 4'ha;
  localparam logic [1:0] TX_DIRECT = 2'h0;
  localparam logic [1:0] TX_MOD_T1 = 2'h1;
  localparam logic [1:0] TX_MOD_T2 = 2'h2;

  // ****************************************
  // Configuration carrier
  // ****************************************
  typedef struct packed {
    logic conv_alt_trigger_enable;
    logic [3:0] conv_trigger_source_select;
    logic conv_pretrigger_ab_select;
    logic timer1_ch0_capture_source;
    logic timer2_ch0_capture_source;
    logic serial0_receive_source;
    logic serial1_receive_source;
    logic [1:0] serial0_transmit_source;
    logic [1:0] serial1_transmit_source;
    logic [NUM_TIMERS-1:0][3:0] timer_trigger_select;
    logic [NUM_TIMERS-1:0] global_timebase_enable;
    logic comparator_trigger_mode;
    logic touch_hw_trigger_en;
    logic dac_hardware_trigger;
    logic dma0_trigger_en;
    logic dma1_trigger_en;
  } trr_cfg_t;

  localparam trr_cfg_t CFG_RESET = '0;

endpackage

/* File: src/trr_router.sv */
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// How it works
// - Alt enable off: channel flags drive A/B.
// - 4-bit selector picks source; pretrigger picks A/B.
// - Comparator output offered as low-power timer input.
// - Comparator selectable as timer1/timer2 capture source.
// - Comparator selectable as serial receive input.
// - Timer1 timebase shared, gated by enable.
// - Low-power timer trigger starts touch scans.
// - Serial transmit modulated by timer channel 0.
// - Periodic flags 0/1 request DMA 0/1.
module trr_router (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_trigger_pin,
  input wire logic comparator_output,
  input wire logic periodic_flag_0,
  input wire logic periodic_flag_1,
  input wire logic [2:0] counter_overflow_flag,
  input wire logic rtc_alarm,
  input wire logic rtc_seconds,
  input wire logic lowpower_timer_trigger,
  input wire logic timer1_channel0_flag,
  input wire logic timer1_channel1_flag,
  input wire logic timer1_ch0_output,
  input wire logic timer2_ch0_output,
  input wire logic timer1_timebase,
  input wire logic serial0_rx_pin,
  input wire logic serial1_rx_pin,
  input wire logic serial0_tx_data,
  input wire logic serial1_tx_data,
  output logic conv_trigger_a,
  output logic conv_trigger_b,
  output logic [2:0] timer_trigger,
  output logic [2:0] global_timebase,
  output logic timer1_ch0_capture_in,
  output logic timer2_ch0_capture_in,
  output logic lowpower_timer_alt_input0,
  output logic comparator_trigger,
  output logic touch_trigger,
  output logic dac_trigger,
  output logic dma_request_0,
  output logic dma_request_1,
  output logic serial0_rx_out,
  output logic serial1_rx_out,
  output logic serial0_tx_out,
  output logic serial1_tx_out
);

  // ****************************************
  // Configuration registers
  // ****************************************
  trr_pkg::trr_cfg_t cfg_r;
  trr_pkg::trr_cfg_t cfg_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  wire logic setup_ph = psel & ~penable;
  wire logic access_ph = psel & penable;
  wire logic hit_cto = paddr == trr_pkg::CONV_TRIGGER_OPTIONS_OFS;
  wire logic hit_tso = paddr == trr_pkg::TIMER_SOURCE_OPTIONS_OFS;
  wire logic hit_sso = paddr == trr_pkg::SERIAL_SOURCE_OPTIONS_OFS;
  wire logic hit_ttc = paddr == trr_pkg::TIMER_TRIGGER_CONFIG_OFS;
  wire logic hit_ren = paddr == trr_pkg::ROUTE_ENABLE_OFS;
  wire logic hit_sts = paddr == trr_pkg::SOURCE_STATUS_OFS;
  wire logic hit_any = hit_cto | hit_tso | hit_sso | hit_ttc | hit_ren | hit_sts;
  wire logic wr_en = access_ph & pwrite;
  // Zero wait states; read data was captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access_ph & ~hit_any;
  assign prdata = prdata_r;

  // ****************************************
  // Source synchroniser and edge detect
  // ****************************************
  logic [trr_pkg::NUM_EV-1:0] ev_raw;
  logic [trr_pkg::NUM_EV-1:0] sync1_r;
  logic [trr_pkg::NUM_EV-1:0] sync2_r;
  logic [trr_pkg::NUM_EV-1:0] sync3_r;
  assign ev_raw[trr_pkg::EV_EXT] = external_trigger_pin;
  assign ev_raw[trr_pkg::EV_CMP] = comparator_output;
  assign ev_raw[trr_pkg::EV_PIT0] = periodic_flag_0;
  assign ev_raw[trr_pkg::EV_PIT1] = periodic_flag_1;
  assign ev_raw[trr_pkg::EV_TOF0] = counter_overflow_flag[0];
  assign ev_raw[trr_pkg::EV_TOF1] = counter_overflow_flag[1];
  assign ev_raw[trr_pkg::EV_TOF2] = counter_overflow_flag[2];
  assign ev_raw[trr_pkg::EV_RTC_ALARM] = rtc_alarm;
  assign ev_raw[trr_pkg::EV_RTC_SEC] = rtc_seconds;
  assign ev_raw[trr_pkg::EV_LPT] = lowpower_timer_trigger;
  assign ev_raw[trr_pkg::EV_T1_CHANNEL0_FLAG] = timer1_channel0_flag;
  assign ev_raw[trr_pkg::EV_T1_CHANNEL1_FLAG] = timer1_channel1_flag;
  assign ev_raw[trr_pkg::EV_T1_CH0_OUT] = timer1_ch0_output;
  assign ev_raw[trr_pkg::EV_T2_CH0_OUT] = timer2_ch0_output;

  // Levels come from the second stage; pulses are rising edges of it
  wire logic [trr_pkg::NUM_EV-1:0] lvl = sync2_r;
  wire logic [trr_pkg::NUM_EV-1:0] pulse = sync2_r & ~sync3_r;
  // Edges are found per source before any selection, so moving a
  // selector between two high sources cannot fake an edge.
  function automatic logic pick(input logic [3:0] sel, input logic [trr_pkg::NUM_EV-1:0] p);
    pick = (sel < trr_pkg::NUM_SEL_CODES) ? p[sel] : 1'b0;
  endfunction

  // ****************************************
  // Routing next values
  // ****************************************
  wire logic conv_sel_pulse = pick(cfg_r.conv_trigger_source_select, pulse);
  logic conv_a_nxt;
  logic conv_b_nxt;
  logic [2:0] ttrig_nxt;
  logic [2:0] gtb_nxt;
  // Alternate path off: fixed pair of timer1 channel flags
  always_comb begin
    if (!cfg_r.conv_alt_trigger_enable) begin
      conv_a_nxt = pulse[trr_pkg::EV_T1_CHANNEL0_FLAG];
      conv_b_nxt = pulse[trr_pkg::EV_T1_CHANNEL1_FLAG];
    end else begin
      conv_a_nxt = conv_sel_pulse & ~cfg_r.conv_pretrigger_ab_select;
      conv_b_nxt = conv_sel_pulse & cfg_r.conv_pretrigger_ab_select;
    end
  end
  // Per-timer trigger choice and shared timebase
  always_comb begin
    for (int i = 0; i < trr_pkg::NUM_TIMERS; i++) begin
      ttrig_nxt[i] = pick(cfg_r.timer_trigger_select[i], pulse);
      gtb_nxt[i] = cfg_r.global_timebase_enable[i] & timer1_timebase;
    end
  end

  // Transmit modulation by a timer channel output
  function automatic logic tx_mod(input logic [1:0] sel, input logic d, input logic m1, input logic m2);
    case (sel)
      trr_pkg::TX_MOD_T1: tx_mod = d & m1;
      trr_pkg::TX_MOD_T2: tx_mod = d & m2;
      default: tx_mod = d;
    endcase
  endfunction
  wire logic t1m = lvl[trr_pkg::EV_T1_CH0_OUT];
  wire logic t2m = lvl[trr_pkg::EV_T2_CH0_OUT];
  wire logic cmp_lvl = lvl[trr_pkg::EV_CMP];
  wire logic lpt_pulse = pulse[trr_pkg::EV_LPT];
  wire logic tx0_nxt = tx_mod(cfg_r.serial0_transmit_source, serial0_tx_data, t1m, t2m);
  wire logic tx1_nxt = tx_mod(cfg_r.serial1_transmit_source, serial1_tx_data, t1m, t2m);
  wire logic rx0_nxt = cfg_r.serial0_receive_source ? cmp_lvl : serial0_rx_pin;
  wire logic rx1_nxt = cfg_r.serial1_receive_source ? cmp_lvl : serial1_rx_pin;
  wire logic cap1_nxt = cfg_r.timer1_ch0_capture_source ? cmp_lvl : timer1_ch0_output;
  wire logic cap2_nxt = cfg_r.timer2_ch0_capture_source ? cmp_lvl : timer2_ch0_output;
  wire logic cmp_trig_nxt = cfg_r.comparator_trigger_mode & lpt_pulse;
  wire logic touch_nxt = cfg_r.touch_hw_trigger_en & lpt_pulse;
  wire logic dac_nxt = cfg_r.dac_hardware_trigger & pulse[trr_pkg::EV_PIT0];
  wire logic dma0_nxt = cfg_r.dma0_trigger_en & pulse[trr_pkg::EV_PIT0];
  wire logic dma1_nxt = cfg_r.dma1_trigger_en & pulse[trr_pkg::EV_PIT1];
  // ****************************************
  // Register write and read decode
  // ****************************************
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_en && hit_cto) begin
      cfg_nxt.conv_pretrigger_ab_select = pwdata[trr_pkg::CTO_PRETRIG_BIT];
      cfg_nxt.conv_alt_trigger_enable = pwdata[trr_pkg::CTO_ALT_EN_BIT];
      cfg_nxt.conv_trigger_source_select = pwdata[trr_pkg::CTO_SRC_LSB +: 4];
    end
    if (wr_en && hit_tso) begin
      cfg_nxt.timer1_ch0_capture_source = pwdata[trr_pkg::TSO_T1_CAP_BIT];
      cfg_nxt.timer2_ch0_capture_source = pwdata[trr_pkg::TSO_T2_CAP_BIT];
    end
    if (wr_en && hit_sso) begin
      cfg_nxt.serial0_receive_source = pwdata[trr_pkg::SSO_RX0_BIT];
      cfg_nxt.serial1_receive_source = pwdata[trr_pkg::SSO_RX1_BIT];
      cfg_nxt.serial0_transmit_source = pwdata[trr_pkg::SSO_TX0_LSB +: 2];
      cfg_nxt.serial1_transmit_source = pwdata[trr_pkg::SSO_TX1_LSB +: 2];
    end
    if (wr_en && hit_ttc) begin
      for (int i = 0; i < trr_pkg::NUM_TIMERS; i++) begin
        cfg_nxt.timer_trigger_select[i] = pwdata[i*trr_pkg::TTC_STRIDE +: 4];
        cfg_nxt.global_timebase_enable[i] = pwdata[i*trr_pkg::TTC_STRIDE + trr_pkg::TTC_GTB_BIT];
      end
    end
    if (wr_en && hit_ren) begin
      cfg_nxt.comparator_trigger_mode = pwdata[trr_pkg::REN_CMP_TRIG_BIT];
      cfg_nxt.touch_hw_trigger_en = pwdata[trr_pkg::REN_TOUCH_BIT];
      cfg_nxt.dac_hardware_trigger = pwdata[trr_pkg::REN_DAC_BIT];
      cfg_nxt.dma0_trigger_en = pwdata[trr_pkg::REN_DMA0_BIT];
      cfg_nxt.dma1_trigger_en = pwdata[trr_pkg::REN_DMA1_BIT];
    end
  end

  // Read word assembled in setup, held through access
  always_comb begin
    prdata_nxt = prdata_r;
    if (setup_ph) begin
      prdata_nxt = '0;
      if (hit_cto) begin
        prdata_nxt[trr_pkg::CTO_PRETRIG_BIT] = cfg_r.conv_pretrigger_ab_select;
        prdata_nxt[trr_pkg::CTO_ALT_EN_BIT] = cfg_r.conv_alt_trigger_enable;
        prdata_nxt[trr_pkg::CTO_SRC_LSB +: 4] = cfg_r.conv_trigger_source_select;
      end
      if (hit_tso) begin
        prdata_nxt[trr_pkg::TSO_T1_CAP_BIT] = cfg_r.timer1_ch0_capture_source;
        prdata_nxt[trr_pkg::TSO_T2_CAP_BIT] = cfg_r.timer2_ch0_capture_source;
      end
      if (hit_sso) begin
        prdata_nxt[trr_pkg::SSO_RX0_BIT] = cfg_r.serial0_receive_source;
        prdata_nxt[trr_pkg::SSO_RX1_BIT] = cfg_r.serial1_receive_source;
        prdata_nxt[trr_pkg::SSO_TX0_LSB +: 2] = cfg_r.serial0_transmit_source;
        prdata_nxt[trr_pkg::SSO_TX1_LSB +: 2] = cfg_r.serial1_transmit_source;
      end
      if (hit_ttc) begin
        for (int i = 0; i < trr_pkg::NUM_TIMERS; i++) begin
          prdata_nxt[i*trr_pkg::TTC_STRIDE +: 4] = cfg_r.timer_trigger_select[i];
          prdata_nxt[i*trr_pkg::TTC_STRIDE + trr_pkg::TTC_GTB_BIT] = cfg_r.global_timebase_enable[i];
        end
      end
      if (hit_ren) begin
        prdata_nxt[trr_pkg::REN_CMP_TRIG_BIT] = cfg_r.comparator_trigger_mode;
        prdata_nxt[trr_pkg::REN_TOUCH_BIT] = cfg_r.touch_hw_trigger_en;
        prdata_nxt[trr_pkg::REN_DAC_BIT] = cfg_r.dac_hardware_trigger;
        prdata_nxt[trr_pkg::REN_DMA0_BIT] = cfg_r.dma0_trigger_en;
        prdata_nxt[trr_pkg::REN_DMA1_BIT] = cfg_r.dma1_trigger_en;
      end
      if (hit_sts) begin
        prdata_nxt[trr_pkg::NUM_EV-1:0] = lvl;
      end
    end
  end

  // ****************************************
  // State
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r <= trr_pkg::CFG_RESET;
      prdata_r <= '0;
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      prdata_r <= prdata_nxt;
      sync1_r <= ev_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Every routed output leaves from a flop; one cycle after the pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv_trigger_a <= 1'b0;
      conv_trigger_b <= 1'b0;
      timer_trigger <= '0;
      global_timebase <= '0;
      timer1_ch0_capture_in <= 1'b0;
      timer2_ch0_capture_in <= 1'b0;
      lowpower_timer_alt_input0 <= 1'b0;
      comparator_trigger <= 1'b0;
      touch_trigger <= 1'b0;
      dac_trigger <= 1'b0;
      dma_request_0 <= 1'b0;
      dma_request_1 <= 1'b0;
      serial0_rx_out <= 1'b1;
      serial1_rx_out <= 1'b1;
      serial0_tx_out <= 1'b1;
      serial1_tx_out <= 1'b1;
    end else begin
      conv_trigger_a <= conv_a_nxt;
      conv_trigger_b <= conv_b_nxt;
      timer_trigger <= ttrig_nxt;
      global_timebase <= gtb_nxt;
      timer1_ch0_capture_in <= cap1_nxt;
      timer2_ch0_capture_in <= cap2_nxt;
      lowpower_timer_alt_input0 <= cmp_lvl;
      comparator_trigger <= cmp_trig_nxt;
      touch_trigger <= touch_nxt;
      dac_trigger <= dac_nxt;
      dma_request_0 <= dma0_nxt;
      dma_request_1 <= dma1_nxt;
      serial0_rx_out <= rx0_nxt;
      serial1_rx_out <= rx1_nxt;
      serial0_tx_out <= tx0_nxt;
      serial1_tx_out <= tx1_nxt;
    end
  end

endmodule

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ****************************************
  // Signals, clock and instances
  // ****************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic [13:0] ev;
  logic [4:0] lv;
  logic ca, cb, ct, tt, dt, d0, d1, la, c1, c2, r0, r1, x0, x1;
  logic [2:0] trg, gtb;
  logic [9:0] pv, lvl;
  int num_errors = 0;
  int n_checks = 0;

  always #4 clk = ~clk;

  trr_far_side far (.clk(clk), .ev(ev), .lv(lv));
  trr_router dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_trigger_pin(ev[0]),
    .comparator_output(ev[1]), .periodic_flag_0(ev[2]), .periodic_flag_1(ev[3]), .counter_overflow_flag(ev[6:4]),
    .rtc_alarm(ev[7]), .rtc_seconds(ev[8]), .lowpower_timer_trigger(ev[9]), .timer1_channel0_flag(ev[10]),
    .timer1_channel1_flag(ev[11]), .timer1_ch0_output(ev[12]), .timer2_ch0_output(ev[13]),
    .timer1_timebase(lv[0]), .serial0_rx_pin(lv[1]), .serial1_rx_pin(lv[2]), .serial0_tx_data(lv[3]),
    .serial1_tx_data(lv[4]), .conv_trigger_a(ca), .conv_trigger_b(cb), .timer_trigger(trg), .global_timebase(gtb),
    .timer1_ch0_capture_in(c1), .timer2_ch0_capture_in(c2), .lowpower_timer_alt_input0(la),
    .comparator_trigger(ct), .touch_trigger(tt), .dac_trigger(dt), .dma_request_0(d0), .dma_request_1(d1),
    .serial0_rx_out(r0), .serial1_rx_out(r1), .serial0_tx_out(x0), .serial1_tx_out(x1));
  // Pulse outputs and level outputs gathered for one compare each
  assign pv = {ca, cb, trg, ct, tt, dt, d0, d1};
  assign lvl = {la, c1, c2, r0, r1, x0, x1, gtb};

  // ****************************************
  // Bus, compare and closing tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Watch ten cycles: which pulses came, and did any last two cycles
  task automatic fire(input int idx, input bit hold, input logic [9:0] exp);
    logic [9:0] seen, dbl, prev;
    seen = '0;
    dbl = '0;
    prev = '0;
    fork
      far.pulse(idx, hold);
      repeat (10) begin
        @(posedge clk);
        #1;
        dbl |= pv & prev;
        seen |= pv;
        prev = pv;
      end
    join
    chk("pulses", 32'(exp), 32'(seen));
    chk("long_pulse", 32'h0, 32'(dbl));
  endtask

  // Levels pass through at most three flops; six cycles is ample
  task automatic lvl_chk(input logic [9:0] exp);
    repeat (6) @(posedge clk);
    #1;
    chk("levels", 32'(exp), 32'(lvl));
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk("reset_value", 32'h0, q);
    end
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped_err", 32'h1, 32'(e));
    chk("unmapped_data", 32'h0, q);
    lvl_chk(10'h078);
    far.set_ev(1, 1'b1);
    far.set_ev(12, 1'b1);
    far.set_lv(0, 1'b1);
    far.set_lv(1, 1'b0);
    far.set_lv(2, 1'b0);
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'h27);
    apb(1'b1, 8'h0c, 32'h0010_0000);
    lvl_chk(10'h3f4);
    apb(1'b0, 8'h14, 32'h0);
    chk("source_status", 32'h0000_1002, q);
    far.set_ev(1, 1'b0);
    far.set_ev(12, 1'b0);
    far.set_ev(13, 1'b1);
    lvl_chk(10'h00c);
    apb(1'b1, 8'h04, 32'h0);
    lvl_chk(10'h08c);
    far.set_ev(13, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk("serial_opts", 32'h27, q);
    apb(1'b1, 8'h10, 32'h1f);
    for (int c = 0; c < 10; c++) begin
      apb(1'b1, 8'h00, 32'h80 | (32'(c) << 8));
      apb(1'b1, 8'h0c, 32'h000a_0000 | (32'(c) << 8) | 32'(c));
      fire(c, 0, 10'h260 | (c == 9 ? 10'h018 : 10'h0) | (c == 2 ? 10'h006 : 10'h0) | (c == 3 ? 10'h001 : 10'h0));
    end
    apb(1'b0, 8'h00, 32'h0);
    chk("conv_opts", 32'h980, q);
    apb(1'b1, 8'h00, 32'h981);
    fire(9, 0, 10'h178);
    apb(1'b1, 8'h00, 32'ha80);
    apb(1'b1, 8'h0c, 32'h000a_0a0a);
    fire(0, 0, 10'h000);
    apb(1'b1, 8'h00, 32'h900);
    fire(10, 0, 10'h200);
    fire(11, 0, 10'h100);
    fire(9, 0, 10'h018);
    apb(1'b1, 8'h10, 32'h0);
    fire(2, 0, 10'h000);
    fire(9, 0, 10'h000);
    apb(1'b1, 8'h0c, 32'h0);
    fire(0, 1, 10'h0e0);
    far.set_ev(0, 1'b0);
    give_verdict();
  end
endmodule

/* File: testbench/trr_far_side.sv */
`timescale 1ns/1ps
// ****************************************
// Event sources and serial lines
// ****************************************
module trr_far_side (
  input wire logic clk,
  output logic [13:0] ev,
  output logic [4:0] lv
);
  // Sources idle low, serial lines idle high, timebase low
  initial begin
    ev = 14'h0000;
    lv = 5'h1e;
  end

  // No stop modes are modelled, so A/B pairs need no 10us gap
  // Two-cycle events with a low gap after unless hold keeps them high; periodic flags come from
  // bus-clock timers, receivers assumed to count faster
  task automatic pulse(input int idx, input bit hold);
    @(posedge clk);
    ev[idx] <= 1'b1;
    repeat (2) @(posedge clk);
    if (!hold) begin
      ev[idx] <= 1'b0;
    end
    @(posedge clk);
  endtask

  task automatic set_ev(input int idx, input logic v);
    @(posedge clk);
    ev[idx] <= v;
  endtask

  task automatic set_lv(input int idx, input logic v);
    @(posedge clk);
    lv[idx] <= v;
  endtask
endmodule

/* File: testbench/trr_router_checker.sv */
`timescale 1ns/1ps
// ****************************************
// Port-level checks on the routing fabric
// ****************************************
module trr_router_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic periodic_flag_0,
  input wire logic periodic_flag_1,
  input wire logic lowpower_timer_trigger,
  input wire logic timer1_timebase,
  input wire logic [2:0] timer_trigger,
  input wire logic [2:0] global_timebase,
  input wire logic conv_trigger_a,
  input wire logic comparator_trigger,
  input wire logic touch_trigger,
  input wire logic dac_trigger,
  input wire logic dma_request_0,
  input wire logic dma_request_1
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Bus decode: only the six words answer cleanly
  a_unmapped_err: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access flagged as error");
  // A routed pulse needs its source high three samples earlier
  a_dma0_cause: assert property (dma_request_0 |-> $past(periodic_flag_0, 3))
    else $error("dma request 0 without periodic flag 0");
  a_dma1_cause: assert property (dma_request_1 |-> $past(periodic_flag_1, 3))
    else $error("dma request 1 without periodic flag 1");
  a_dac_cause: assert property (dac_trigger |-> $past(periodic_flag_0, 3))
    else $error("dac trigger without periodic flag 0");
  a_touch_cause: assert property (touch_trigger |-> $past(lowpower_timer_trigger, 3))
    else $error("touch trigger without low-power timer trigger");
  a_cmp_trig_cause: assert property (comparator_trigger |-> $past(lowpower_timer_trigger, 3))
    else $error("comparator trigger without low-power timer trigger");
  // Pulses never stretch, so a held source cannot retrigger
  a_trig_single: assert property (timer_trigger != 3'h0 |=> (timer_trigger & $past(timer_trigger)) == 3'h0)
    else $error("timer trigger longer than one cycle");
  a_conv_single: assert property (conv_trigger_a |=> !conv_trigger_a)
    else $error("converter trigger A longer than one cycle");
  a_gtb_follow: assert property (global_timebase != 3'h0 |-> $past(timer1_timebase))
    else $error("global timebase without timer 1 timebase");

  c_dma0: cover property (dma_request_0);
  c_touch: cover property (touch_trigger);
  c_bus_err: cover property (psel && penable && pslverr);
endmodule

bind trr_router trr_router_checker chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .paddr(paddr), .pslverr(pslverr), .periodic_flag_0(periodic_flag_0), .periodic_flag_1(periodic_flag_1),
  .lowpower_timer_trigger(lowpower_timer_trigger), .timer1_timebase(timer1_timebase),
  .timer_trigger(timer_trigger), .global_timebase(global_timebase), .conv_trigger_a(conv_trigger_a),
  .comparator_trigger(comparator_trigger), .touch_trigger(touch_trigger), .dac_trigger(dac_trigger),
  .dma_request_0(dma_request_0), .dma_request_1(dma_request_1));
